// ==== core/phy_basic_mode_control.sv ====
// basic mode control register with its control and mii loopback logic
//
// Functional notes
// - bit 15 starts reset, reads one, self-clears
// - software reset reloads strap configuration
// - loopback bit 14 routes transmit to receive
// - loopback may blank receive for 500 us
// - speed bit 13 selects 100 or 10
// - autoneg bit 12 set ignores speed, duplex
// - autoneg off: speed and duplex bits rule
// - autoneg enable initial value from strap
// - power down bit 11 stops transceiver
// - isolate bit 10 cuts port from mii
// - restart bit 9 re-initiates autonegotiation
// - restart write ignored while autoneg off
// - restart reads one until negotiation starts
// - clearing restart leaves negotiation undisturbed
// - duplex bit 8 selects full or half
// - collision test asserts col after tx_en
// - collision test drops col after tx_en
// - reserved bits 6:0 ignore writes, read zero
// - self-clearing bits clear when action completes
`include "phy_bmc_consts.svh"
module phy_basic_mode_control #(
  parameter int DEAD_CYCLES = `BMC_DEAD_TIME_NS / `BMC_CLOCK_PERIOD_NS
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire phy_bmc_pkg::mgmt_req_s mgmt_i,
  output logic [15:0] read_data_o,
  output logic read_valid_o,
  input wire logic strap_autoneg_i,
  input wire logic strap_speed_i,
  input wire logic strap_duplex_i,
  input wire logic an_started_i,
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  input wire phy_bmc_pkg::mii_nibble_s mii_tx_i,
  input wire phy_bmc_pkg::mii_nibble_s line_rx_i,
  input wire logic line_col_i,
  output phy_bmc_pkg::mii_nibble_s mii_rx_o,
  output logic mii_rx_oe_o,
  output logic mii_col_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic autoneg_en_o,
  output logic an_restart_o,
  output logic power_down_o,
  output logic isolate_o,
  output logic loopback_o,
  output logic phy_reset_o
);
  localparam int DEAD_W = $clog2(DEAD_CYCLES + 1);

  phy_bmc_pkg::ctl_state_e state;
  logic [15:0] count;
  logic [DEAD_W-1:0] dead_count;
  logic loopback, speed, autoneg, power_down, isolate, restart, duplex, col_test;
  logic [2:0] strap_meta, strap_sync;
  phy_bmc_pkg::mii_nibble_s tx_meta, tx_sync;
  logic wr_hit;
  logic sw_start;
  logic strap_load;
  logic [15:0] reg_value;

  function automatic logic addr_hit(input phy_bmc_pkg::mgmt_req_s req);
    addr_hit = (req.addr == `BMC_REG_ADDR);
  endfunction

  // register image; reserved bits stay zero
  function automatic logic [15:0] pack_value(input logic busy, input logic [7:0] b);
    logic [15:0] v;
    v = `BMC_ZERO16;
    v[`BMC_RESET_BIT] = busy;
    v[`BMC_LOOPBACK_BIT:`BMC_COL_TEST_BIT] = b;
    pack_value = v;
  endfunction

  assign wr_hit = mgmt_i.wr && addr_hit(mgmt_i) && (state == phy_bmc_pkg::CTL_RUN);
  assign sw_start = wr_hit && mgmt_i.wdata[`BMC_RESET_BIT];
  assign strap_load = (state != phy_bmc_pkg::CTL_RUN) && (count == `BMC_COUNT_LAST);
  assign reg_value = pack_value(state == phy_bmc_pkg::CTL_SWRESET,
                                {loopback, speed, autoneg, power_down, isolate, restart, duplex, col_test});

  // strap pins pass two flops
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end
    else
    begin
      strap_meta <= {strap_autoneg_i, strap_speed_i, strap_duplex_i};
      strap_sync <= strap_meta;
    end
  end

  // transmit pins pass two flops
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      tx_meta <= '0;
      tx_sync <= '0;
    end
    else
    begin
      tx_meta <= mii_tx_i;
      tx_sync <= tx_meta;
    end
  end

  // settle after hardware reset, software reset sequence
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state <= phy_bmc_pkg::CTL_SETTLE;
      count <= `BMC_STRAP_SETTLE_CYCLES;
    end
    else
    begin
      case (state)
        phy_bmc_pkg::CTL_SETTLE, phy_bmc_pkg::CTL_SWRESET:
        begin
          if (count == `BMC_COUNT_LAST)
            state <= phy_bmc_pkg::CTL_RUN;
          count <= count - `BMC_COUNT_LAST;
        end
        phy_bmc_pkg::CTL_RUN:
        begin
          if (sw_start)
          begin
            state <= phy_bmc_pkg::CTL_SWRESET;
            count <= `BMC_SOFT_RESET_CYCLES;
          end
        end
        default:
        begin
          state <= phy_bmc_pkg::CTL_SETTLE;
          count <= `BMC_STRAP_SETTLE_CYCLES;
        end
      endcase
    end
  end

  // plain read-write fields
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      loopback <= 1'b0;
      power_down <= 1'b0;
      isolate <= 1'b0;
      col_test <= 1'b0;
      autoneg <= 1'b0;
      speed <= 1'b0;
      duplex <= 1'b0;
    end
    else if (strap_load)
    begin
      autoneg <= strap_sync[2];
      speed <= strap_sync[1];
      duplex <= strap_sync[0];
    end
    else if (sw_start)
    begin
      loopback <= 1'b0;
      power_down <= 1'b0;
      isolate <= 1'b0;
      col_test <= 1'b0;
    end
    else if (wr_hit)
    begin
      loopback <= mgmt_i.wdata[`BMC_LOOPBACK_BIT];
      speed <= mgmt_i.wdata[`BMC_SPEED_BIT];
      autoneg <= mgmt_i.wdata[`BMC_AUTONEG_BIT];
      power_down <= mgmt_i.wdata[`BMC_POWER_DOWN_BIT];
      isolate <= mgmt_i.wdata[`BMC_ISOLATE_BIT];
      duplex <= mgmt_i.wdata[`BMC_DUPLEX_BIT];
      col_test <= mgmt_i.wdata[`BMC_COL_TEST_BIT];
    end
  end

  // restart bit: pending until the negotiation engine starts
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      restart <= 1'b0;
      an_restart_o <= 1'b0;
    end
    else
    begin
      an_restart_o <= wr_hit && !sw_start && mgmt_i.wdata[`BMC_RESTART_BIT]
                      && mgmt_i.wdata[`BMC_AUTONEG_BIT];
      if (sw_start || strap_load)
        restart <= 1'b0;
      else if (wr_hit)
        restart <= mgmt_i.wdata[`BMC_RESTART_BIT] && mgmt_i.wdata[`BMC_AUTONEG_BIT];
      else if (an_started_i)
        restart <= 1'b0;
    end
  end

  // operating mode toward the rest of the transceiver
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      speed_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
      autoneg_en_o <= 1'b0;
      power_down_o <= 1'b0;
      isolate_o <= 1'b0;
      loopback_o <= 1'b0;
      phy_reset_o <= 1'b1;
    end
    else
    begin
      speed_100_o <= autoneg ? an_speed_100_i : speed;
      full_duplex_o <= autoneg ? an_full_duplex_i : duplex;
      autoneg_en_o <= autoneg;
      power_down_o <= power_down;
      isolate_o <= isolate;
      loopback_o <= loopback;
      phy_reset_o <= (state != phy_bmc_pkg::CTL_RUN);
    end
  end

  // descrambler dead time after loopback is switched on
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      dead_count <= '0;
    else if (wr_hit && !sw_start && mgmt_i.wdata[`BMC_LOOPBACK_BIT] && !loopback)
      dead_count <= DEAD_W'(DEAD_CYCLES);
    else if (dead_count != '0)
      dead_count <= dead_count - DEAD_W'(1);
  end

  // receive side: loopback, isolate, power down, collision test
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      mii_rx_o <= '0;
      mii_rx_oe_o <= 1'b0;
      mii_col_o <= 1'b0;
    end
    else if (isolate || power_down)
    begin
      mii_rx_o <= '0;
      mii_rx_oe_o <= 1'b0;
      mii_col_o <= 1'b0;
    end
    else
    begin
      mii_rx_oe_o <= 1'b1;
      if (loopback)
      begin
        mii_rx_o.data <= tx_sync.data;
        mii_rx_o.en <= tx_sync.en && (dead_count == '0);
      end
      else
        mii_rx_o <= line_rx_i;
      if (col_test)
        mii_col_o <= tx_sync.en;
      else
        mii_col_o <= line_col_i && !loopback;
    end
  end

  // register read port
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      read_data_o <= `BMC_ZERO16;
      read_valid_o <= 1'b0;
    end
    else
    begin
      read_valid_o <= mgmt_i.rd;
      read_data_o <= addr_hit(mgmt_i) ? reg_value : `BMC_ZERO16;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  a_reset_bit_clears: assert property ((state == phy_bmc_pkg::CTL_SWRESET) |-> ##[1:40] (state == phy_bmc_pkg::CTL_RUN))
    else $error("software reset did not self-clear");
  a_reset_bit_reads: assert property ((state == phy_bmc_pkg::CTL_SWRESET) && mgmt_i.rd |=> read_data_o[`BMC_RESET_BIT])
    else $error("reset bit not read as one during reset");
  a_strap_reload: assert property (strap_load |=> autoneg == $past(strap_sync[2]) && speed == $past(strap_sync[1]))
    else $error("strap values not reloaded");
  a_loop_route: assert property (loopback && !isolate && !power_down |=> mii_rx_o.data == $past(tx_sync.data))
    else $error("loopback data not routed");
  a_dead_quiet: assert property (loopback && !isolate && !power_down && dead_count != '0 |=> !mii_rx_o.en)
    else $error("receive valid during dead time");
  a_forced_mode: assert property (!autoneg |=> speed_100_o == $past(speed) && full_duplex_o == $past(duplex))
    else $error("forced speed or duplex not applied");
  a_an_ignores_bits: assert property (autoneg |=> speed_100_o == $past(an_speed_100_i))
    else $error("speed bit used while autoneg on");
  a_power_isolate: assert property (power_down || isolate |=> !mii_rx_oe_o && !mii_col_o)
    else $error("mii driven while powered down or isolated");
  a_restart_ignored: assert property (wr_hit && !mgmt_i.wdata[`BMC_AUTONEG_BIT] |=> !restart && !an_restart_o)
    else $error("restart accepted with autoneg off");
  a_restart_holds: assert property (restart && !an_started_i && !wr_hit && !sw_start |=> restart)
    else $error("restart cleared before negotiation began");
  a_col_test: assert property (col_test && !isolate && !power_down && tx_sync.en |=> mii_col_o)
    else $error("collision test did not assert col");
  a_col_release: assert property (col_test && !tx_sync.en |=> !mii_col_o)
    else $error("collision test col not released");
  a_reserved_zero: assert property (mgmt_i.rd |=> read_data_o[`BMC_RSVD_MSB:0] == 7'h00)
    else $error("reserved bits read nonzero");

  c_soft_reset: cover property (sw_start ##[1:40] (state == phy_bmc_pkg::CTL_RUN));
  c_restart_done: cover property (an_restart_o ##[1:20] (an_started_i && !restart));
  c_loop_data: cover property (loopback && dead_count == '0 && mii_rx_o.en);
  c_col_test: cover property (col_test && mii_col_o);
endmodule

// ==== shared/phy_bmc_consts.svh ====
// constants for the basic mode control register block
`ifndef PHY_BMC_CONSTS_SVH
`define PHY_BMC_CONSTS_SVH
`define BMC_REG_ADDR 5'h00
`define BMC_RESET_BIT 15
`define BMC_LOOPBACK_BIT 14
`define BMC_SPEED_BIT 13
`define BMC_AUTONEG_BIT 12
`define BMC_POWER_DOWN_BIT 11
`define BMC_ISOLATE_BIT 10
`define BMC_RESTART_BIT 9
`define BMC_DUPLEX_BIT 8
`define BMC_COL_TEST_BIT 7
`define BMC_RSVD_MSB 6
`define BMC_ZERO16 16'h0000
`define BMC_CLOCK_PERIOD_NS 40
`define BMC_DEAD_TIME_NS 500000
`define BMC_SOFT_RESET_CYCLES 16'h0020
`define BMC_STRAP_SETTLE_CYCLES 16'h0003
`define BMC_COUNT_LAST 16'h0001
`endif

// ==== shared/phy_bmc_pkg.sv ====
// types for the basic mode control register block
package phy_bmc_pkg;
  typedef enum logic [2:0] {
    CTL_SETTLE = 3'b001,
    CTL_RUN = 3'b010,
    CTL_SWRESET = 3'b100
  } ctl_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_s;

  typedef struct packed {
    logic en;
    logic [3:0] data;
  } mii_nibble_s;
endpackage

// ==== sim/mgmt_station.sv ====
// station management model issuing register requests
module mgmt_station (
  input wire logic clock_i,
  input wire logic [15:0] read_data_i,
  input wire logic read_valid_i,
  output phy_bmc_pkg::mgmt_req_s req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // one-cycle strobe; released data shows the inverse
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
  endtask
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge clock_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hffff};
    @(posedge clock_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: 16'h0000};
    #1;
    d = read_data_i;
    v = read_valid_i;
  endtask
endmodule

// ==== sim/tb_phy_basic_mode_control.sv ====
// self-checking bench for the basic mode control register
module tb_phy_basic_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, reset_i, st_an, st_spd, st_dup, an_go, an_spd, an_fd, v, rx_oe, col;
  logic spd, fd, an_en, pdn, iso, lpb, prst, rvalid;
  logic line_col, an_rst;
  logic [15:0] rdata, rd, w;
  logic [3:0] d;
  phy_bmc_pkg::mgmt_req_s mgmt;
  phy_bmc_pkg::mii_nibble_s mii_tx, line_rx, mii_rx;
  int n_mismatch, tests_run;
  mgmt_station host (.clock_i(clock_i), .read_data_i(rdata), .read_valid_i(rvalid), .req_o(mgmt));
  phy_basic_mode_control #(.DEAD_CYCLES(20)) dut (.clock_i(clock_i), .reset_i(reset_i), .mgmt_i(mgmt),
    .read_data_o(rdata), .read_valid_o(rvalid), .strap_autoneg_i(st_an), .strap_speed_i(st_spd),
    .strap_duplex_i(st_dup), .an_started_i(an_go), .an_speed_100_i(an_spd), .an_full_duplex_i(an_fd),
    .mii_tx_i(mii_tx), .line_rx_i(line_rx), .line_col_i(line_col), .mii_rx_o(mii_rx), .mii_rx_oe_o(rx_oe),
    .mii_col_o(col), .speed_100_o(spd), .full_duplex_o(fd), .autoneg_en_o(an_en), .an_restart_o(an_rst),
    .power_down_o(pdn), .isolate_o(iso), .loopback_o(lpb), .phy_reset_o(prst));
  function automatic logic [15:0] strap_image();
    return {2'b00, st_spd, st_an, 3'b000, st_dup, 8'h00};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic rd_chk(input string name, input logic [15:0] exp);
    host.read_reg(5'h00, rd, v);
    check("read valid", 16'(v), 16'h0001);
    check(name, rd, exp);
  endtask
  task automatic wr_pulse(input logic [15:0] x, input logic exp);
    host.write_reg(5'h00, x);
    #1;
    check("restart pulse", 16'(an_rst), 16'(exp));
  endtask
  task automatic mode_chk(input logic [15:0] x);
    cyc(3);
    #1;
    check("speed", 16'(spd), 16'(x[12] ? an_spd : x[13]));
    check("duplex", 16'(fd), 16'(x[12] ? an_fd : x[8]));
    check("modes", {12'h000, an_en, pdn, iso, lpb}, {12'h000, x[12], x[11], x[10], x[14]});
    check("rx enable", 16'(rx_oe), 16'(!(x[11] | x[10])));
    check("rx data", 16'(mii_rx), (x[14] | x[11] | x[10]) ? 16'h0000 : 16'(line_rx));
    check("line col", 16'(col), 16'(line_col & !(x[14] | x[11] | x[10] | x[7])));
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(27));
    reset_i = 1'b1;
    {st_an, st_spd, st_dup, an_go, an_spd, an_fd} = 6'b011001;
    mii_tx = '0;
    line_rx = '0;
    line_col = 1'b0;
    cyc(2);
    reset_i <= 1'b0;
    cyc(8);
    rd_chk("after reset", strap_image());
    host.read_reg(5'h05, rd, v);
    check("unmapped", rd, 16'h0000);
    w = 16'h7d7f;
    for (int i = 0; i < 8; i++)
    begin
      an_spd <= 1'($urandom());
      an_fd <= 1'($urandom());
      line_rx <= 5'($urandom());
      line_col <= 1'($urandom());
      host.write_reg(5'h00, w);
      mode_chk(w);
      rd_chk("rw bits", w & 16'h7d80);
      w = 16'($urandom()) & 16'h7dff;
    end
    wr_pulse(16'h0200, 1'b0);
    rd_chk("restart off", 16'h0000);
    wr_pulse(16'h1200, 1'b1);
    rd_chk("restart held", 16'h1200);
    wr_pulse(16'h1000, 1'b0);
    rd_chk("restart cleared", 16'h1000);
    wr_pulse(16'h1200, 1'b1);
    an_go <= 1'b1;
    @(posedge clock_i);
    an_go <= 1'b0;
    rd_chk("restart done", 16'h1000);
    d = 4'($urandom());
    host.write_reg(5'h00, 16'h6100);
    mii_tx <= '{en: 1'b1, data: d};
    cyc(4);
    #1;
    check("dead time", 16'(mii_rx.en), 16'h0000);
    cyc(30);
    #1;
    check("loopback", 16'(mii_rx), {11'h000, 1'b1, d});
    mii_tx <= '0;
    host.write_reg(5'h00, 16'h0080);
    cyc(4);
    mii_tx <= '{en: 1'b1, data: d};
    cyc(5);
    #1;
    check("col on", 16'(col), 16'h0001);
    mii_tx <= '0;
    cyc(5);
    #1;
    check("col off", 16'(col), 16'h0000);
    host.write_reg(5'h00, 16'h4e80);
    {st_an, st_spd, st_dup} <= 3'b100;
    cyc(5);
    host.write_reg(5'h00, 16'h8000);
    host.read_reg(5'h00, rd, v);
    check("reset running", {14'h0000, rd[15], prst}, 16'h0003);
    cyc(40);
    rd_chk("reset done", strap_image());
    report_and_stop();
  end
endmodule
